// ==== usb_host_cfg.svh ====
/*
 * Constants of the host port wrapper: register offsets, field positions,
 * counts and reset values.
 * Assumes inclusion by bare name from the port block module; the package does not include it.
 */
`ifndef USB_HOST_CFG_SVH
`define USB_HOST_CFG_SVH

// register offsets of the operational slave port
`define REG_CONTROL     4'h0
`define REG_STATUS      4'h1
`define REG_PORTS       4'h2
`define REG_LIST_BASE   4'h3
// control fields
`define CTL_RUN         0
`define CTL_IRQ_EN      1
`define CTL_OC_EN       2
`define CTL_PWR_LO      3
`define CTL_RST_LO      5
// status fields and control reset value
`define STS_UERR        0
`define STS_CONN_CHG    1
`define CTL_RESET_VAL   32'h0000_0018
// counts
`define NUM_PORTS       4'h2
`define NUM_PORTS_SHARED 4'h1
`define UTMI_DIVIDER    4'h9
`define FS_DIV_LAST     2'h3
`define DATA_WORDS_LAST 2'h3
`define FIFO_DEPTH      16
`define WORD_W          32
`define SYNC_W          8

`endif

// ==== usb_host_pkg.sv ====
/*
 * Types of the host port wrapper.
 * Assumes the constants header is on the include path.
 */
package usb_host_pkg;
	// descriptor engine states
	typedef enum logic [2:0] {
		st_idle,
		st_ed_fetch,
		st_td_fetch,
		st_data_read,
		st_status_write
	} master_state_e;
endpackage

// ==== usb_host_fifo.sv ====
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module usb_host_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             clock_i,
	input  wire logic             reset_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_q[rd_q];

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // usb_host_fifo

// ==== usb_host_port_block.sv ====
/*
 * Host port integration: operational slave port, descriptor master,
 * root hub connect sensing, transceiver sharing and clock gating.
 * Assumes the clock unit drives lock, enables and 48 MHz ticks on clock_i.
 */
// Contract
// - operational registers reachable only through the slave port
// - master fetches descriptors, moves data, writes back status
// - bus abort or misaligned access sets the unrecoverable-error flag
// - root hub port count readable in operational registers
// - device attach detected by hardware without polling
// - host can activate over-current protection; no dedicated pads
// - transceiver data lines driven only by host and device controller
// - with second transceiver given away, host runs port A only
// - device-port enable moves second transceiver to device controller
// - high-speed needs the running, locked 48 MHz UTMI PLL
// - transceiver returns a 30 MHz clock for high-speed logic
// - full-speed 12 MHz clock is the 48 MHz input divided by four
// - main PLL source keeps full-speed working with UTMI PLL off
// - single interrupt line; interrupt controller configured first
`timescale 1ns/1ps
`include "usb_host_cfg.svh"
module usb_host_port_block (
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	// operational slave port
	input  wire logic        op_req_i,
	input  wire logic        op_we_i,
	input  wire logic [3:0]  op_addr_i,
	input  wire logic [31:0] op_wdata_i,
	output logic      [31:0] op_rdata_o,
	// system bus master
	output logic             mst_req_o,
	output logic             mst_we_o,
	output logic      [31:0] mst_addr_o,
	output logic      [31:0] mst_wdata_o,
	input  wire logic        mst_ack_i,
	input  wire logic        mst_err_i,
	input  wire logic [31:0] mst_rdata_i,
	// endpoint data toward the port serializer
	output logic             tx_valid_o,
	input  wire logic        tx_ready_i,
	output logic      [31:0] tx_data_o,
	// clock unit
	input  wire logic        utmi_pll_enable_bit_i,
	input  wire logic        utmi_pll_lock_flag_i,
	input  wire logic        transceiver_bias_enable_i,
	input  wire logic        xcvr_30m_valid_i,
	input  wire logic        fullspeed_clock_source_select_i,
	input  wire logic [3:0]  fullspeed_clock_divider_i,
	input  wire logic        host_clock_enable_bit_i,
	input  wire logic        host_48m_tick_i,
	output logic             host_12m_tick_o,
	output logic             hs_available_o,
	output logic             fs_ready_o,
	output logic             clock_config_error_o,
	// transceiver sense
	input  wire logic [1:0]  port_a_line_state_i,
	input  wire logic [1:0]  port_b_line_state_i,
	input  wire logic [1:0]  oc_sense_i,
	output logic      [1:0]  port_power_o,
	// port A lines, bit 1 plus, bit 0 minus
	output logic      [1:0]  port_a_fullspeed_o,
	output logic             port_a_fullspeed_oe_o,
	output logic      [1:0]  port_a_highspeed_o,
	output logic             port_a_highspeed_oe_o,
	// shared port B lines and device controller
	input  wire logic        device_port_enable_i,
	input  wire logic [1:0]  device_fullspeed_i,
	input  wire logic        device_fullspeed_oe_i,
	input  wire logic [1:0]  device_highspeed_i,
	input  wire logic        device_highspeed_oe_i,
	output logic      [1:0]  port_b_fullspeed_o,
	output logic             port_b_fullspeed_oe_o,
	output logic      [1:0]  port_b_highspeed_o,
	output logic             port_b_highspeed_oe_o,
	output logic             irq_o
);
	usb_host_pkg::master_state_e state_q;
	logic [31:0]        control_q, list_base_q, addr_q;
	logic               uerr_q;
	logic [1:0]         conn_chg_q, conn_prev_q, words_q, fs_div_q;
	logic [`SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
	logic [1:0]         line_a, line_b, oc_sync, connected, port_active;
	logic               lock_sync, x30_sync, misaligned, access_ok, mst_fail, fifo_ready, wr_sts;

	// ======================================================================
	// input synchronisers
	assign {line_b, line_a, oc_sync, lock_sync, x30_sync} = filt_q;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			filt_q <= '0;
		end else begin
			s1_q   <= {port_b_line_state_i, port_a_line_state_i, oc_sense_i,
				utmi_pll_lock_flag_i, xcvr_30m_valid_i};
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			// change taken once second and third stage agree
			filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
		end
	end

	// ======================================================================
	// clocks
	assign hs_available_o = utmi_pll_enable_bit_i && lock_sync && transceiver_bias_enable_i
		&& x30_sync;
	assign fs_ready_o = host_clock_enable_bit_i
		&& (!fullspeed_clock_source_select_i || hs_available_o);
	assign clock_config_error_o = fullspeed_clock_source_select_i
		&& (fullspeed_clock_divider_i != `UTMI_DIVIDER);
	assign host_12m_tick_o = fs_ready_o && host_48m_tick_i && (fs_div_q == `FS_DIV_LAST);

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			fs_div_q <= '0;
		end else if (!fs_ready_o) begin
			fs_div_q <= '0;
		end else if (host_48m_tick_i) begin
			fs_div_q <= fs_div_q + 2'h1;
		end
	end

	// ======================================================================
	// operational slave port
	assign wr_sts = op_req_i && op_we_i && (op_addr_i == `REG_STATUS);

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			control_q   <= `CTL_RESET_VAL;
			list_base_q <= '0;
		end else if (op_req_i && op_we_i) begin
			if (op_addr_i == `REG_CONTROL) begin
				control_q <= op_wdata_i;
			end
			if (op_addr_i == `REG_LIST_BASE) begin
				list_base_q <= op_wdata_i;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			op_rdata_o <= '0;
		end else if (op_req_i && !op_we_i) begin
			case (op_addr_i)
				`REG_CONTROL:   op_rdata_o <= control_q;
				`REG_STATUS:    op_rdata_o <= {26'h0, fs_ready_o, hs_available_o,
					(state_q != usb_host_pkg::st_idle), conn_chg_q, uerr_q};
				`REG_PORTS:     op_rdata_o <= {22'h0, connected, 4'h0,
					device_port_enable_i ? `NUM_PORTS_SHARED : `NUM_PORTS};
				`REG_LIST_BASE: op_rdata_o <= list_base_q;
				default:        op_rdata_o <= '0;
			endcase
		end
	end

	// ======================================================================
	// root hub ports
	assign port_active = {!device_port_enable_i, 1'b1};
	assign connected   = {line_b != 2'h0, line_a != 2'h0} & port_active;

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			conn_prev_q <= '0;
			conn_chg_q  <= '0;
		end else begin
			conn_prev_q <= connected;
			// write one clears, a new change wins
			conn_chg_q  <= (conn_chg_q & ~({2{wr_sts}} & op_wdata_i[`STS_CONN_CHG +: 2]))
				| (connected ^ conn_prev_q);
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			port_power_o <= '0;
		end else begin
			port_power_o <= control_q[`CTL_PWR_LO +: 2] & port_active
				& ~({2{control_q[`CTL_OC_EN]}} & oc_sync);
		end
	end

	// host drives bus reset only; no GPIO path exists to these lines
	assign port_a_fullspeed_o    = 2'h0;
	assign port_a_fullspeed_oe_o = control_q[`CTL_RST_LO] && port_power_o[0];
	assign port_a_highspeed_o    = 2'h0;
	assign port_a_highspeed_oe_o = port_a_fullspeed_oe_o && hs_available_o;
	assign port_b_fullspeed_o    = device_port_enable_i ? device_fullspeed_i : 2'h0;
	assign port_b_fullspeed_oe_o = device_port_enable_i ? device_fullspeed_oe_i
		: (control_q[`CTL_RST_LO+1] && port_power_o[1]);
	assign port_b_highspeed_o    = device_port_enable_i ? device_highspeed_i : 2'h0;
	assign port_b_highspeed_oe_o = device_port_enable_i ? device_highspeed_oe_i
		: (control_q[`CTL_RST_LO+1] && port_power_o[1] && hs_available_o);

	// ======================================================================
	// descriptor master
	assign misaligned = (addr_q[1:0] != 2'h0);
	assign access_ok  = (state_q != usb_host_pkg::st_idle) && !misaligned
		&& ((state_q != usb_host_pkg::st_data_read) || fifo_ready);
	assign mst_req_o  = access_ok;
	assign mst_we_o   = (state_q == usb_host_pkg::st_status_write);
	assign mst_addr_o = addr_q;
	assign mst_fail   = (state_q != usb_host_pkg::st_idle) && (misaligned || (access_ok && mst_err_i));

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state_q     <= usb_host_pkg::st_idle;
			addr_q      <= '0;
			words_q     <= '0;
			mst_wdata_o <= '0;
		end else if (mst_fail) begin
			state_q <= usb_host_pkg::st_idle;
		end else begin
			case (state_q)
				usb_host_pkg::st_idle: begin
					if (control_q[`CTL_RUN] && !uerr_q && fs_ready_o) begin
						addr_q  <= list_base_q;
						state_q <= usb_host_pkg::st_ed_fetch;
					end
				end
				usb_host_pkg::st_ed_fetch: begin
					if (mst_ack_i) begin
						addr_q  <= mst_rdata_i;
						state_q <= usb_host_pkg::st_td_fetch;
					end
				end
				usb_host_pkg::st_td_fetch: begin
					if (mst_ack_i) begin
						mst_wdata_o <= addr_q;
						addr_q      <= mst_rdata_i;
						words_q     <= '0;
						state_q     <= usb_host_pkg::st_data_read;
					end
				end
				usb_host_pkg::st_data_read: begin
					if (access_ok && mst_ack_i) begin
						addr_q  <= addr_q + 32'h4;
						words_q <= words_q + 2'h1;
						if (words_q == `DATA_WORDS_LAST) begin
							addr_q  <= mst_wdata_o;
							state_q <= usb_host_pkg::st_status_write;
						end
					end
				end
				usb_host_pkg::st_status_write: begin
					if (mst_ack_i) begin
						state_q <= usb_host_pkg::st_idle;
					end
				end
				default: state_q <= usb_host_pkg::st_idle;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			uerr_q <= 1'b0;
		end else begin
			uerr_q <= mst_fail || (uerr_q && !(wr_sts && op_wdata_i[`STS_UERR]));
		end
	end

	usb_host_fifo #(
		.WIDTH (`WORD_W),
		.DEPTH (`FIFO_DEPTH)
	) data_fifo (
		.clock_i     (clock_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  ((state_q == usb_host_pkg::st_data_read) && access_ok && mst_ack_i && !mst_err_i),
		.in_ready_o  (fifo_ready),
		.in_data_i   (mst_rdata_i),
		.out_valid_o (tx_valid_o),
		.out_ready_i (tx_ready_i),
		.out_data_o  (tx_data_o)
	);

	assign irq_o = control_q[`CTL_IRQ_EN] && (uerr_q || (|conn_chg_q));

	// ======================================================================
	// assertions
	uerr_on_abort_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		mst_req_o && mst_err_i |=> uerr_q && state_q == usb_host_pkg::st_idle)
		else $error("bus abort did not set the error flag");
	misalign_no_req_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		misaligned && state_q != usb_host_pkg::st_idle |-> !mst_req_o ##1 uerr_q)
		else $error("misaligned access was issued or not flagged");
	port_count_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		op_req_i && !op_we_i && op_addr_i == `REG_PORTS && !device_port_enable_i
		|=> op_rdata_o[3:0] == `NUM_PORTS)
		else $error("port count read wrong");
	attach_flag_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		$rose(connected[0]) |=> conn_chg_q[0])
		else $error("attach detection broken");
	attach_seen_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		connected != conn_prev_q |=> conn_chg_q != 2'h0)
		else $error("attach not flagged");
	oc_cut_power_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		control_q[`CTL_OC_EN] && oc_sync[0] |=> !port_power_o[0])
		else $error("over-current did not cut power");
	port_b_device_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		device_port_enable_i |-> port_b_fullspeed_o == device_fullspeed_i
		&& port_b_highspeed_oe_o == device_highspeed_oe_i && !connected[1])
		else $error("port B not handed to device");
	hs_gated_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		!lock_sync |-> !hs_available_o && !port_a_highspeed_oe_o)
		else $error("high speed active without PLL lock");
	fs_divide_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		host_12m_tick_o |=> !host_12m_tick_o [*3])
		else $error("12 MHz tick faster than a quarter");
	fs_main_src_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		host_clock_enable_bit_i && !fullspeed_clock_source_select_i |-> fs_ready_o)
		else $error("full speed lost on main PLL");
	order_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		$changed(state_q) && state_q == usb_host_pkg::st_status_write
		|-> $past(state_q) == usb_host_pkg::st_data_read)
		else $error("status written out of order");
	irq_line_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		control_q[`CTL_IRQ_EN] && mst_fail |=> irq_o)
		else $error("error did not raise interrupt");

	transfer_done_c: cover property (@(posedge clock_i) disable iff (!reset_n_i)
		state_q == usb_host_pkg::st_status_write && mst_ack_i);
	fifo_full_c: cover property (@(posedge clock_i) disable iff (!reset_n_i)
		state_q == usb_host_pkg::st_data_read && !fifo_ready);
	attach_c: cover property (@(posedge clock_i) disable iff (!reset_n_i)
		$rose(connected[0]));
endmodule // usb_host_port_block

// ==== sys_memory_model.sv ====
/*
 * System memory model answering the host port's bus master.
 * Assumes a request is held until ack or err, all on one clock.
 */
`timescale 1ns/1ps
module sys_memory_model (
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	input  wire logic        req_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [3:0]  latency_i,
	input  wire logic [31:0] err_addr_i,
	output logic             ack_o,
	output logic             err_o,
	output logic      [31:0] rdata_o
);
	logic [3:0] wait_q;

	// ========================================
	// answer latency_i+1 cycles after the request; word holds its address plus 0x100
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			wait_q  <= 4'h0;
			ack_o   <= 1'b0;
			err_o   <= 1'b0;
			rdata_o <= 32'hA5A5_5A5A;
		end else if (!req_i || ack_o || err_o) begin
			wait_q  <= 4'h0;
			ack_o   <= 1'b0;
			err_o   <= 1'b0;
			rdata_o <= ~rdata_o;
		end else if (wait_q == latency_i) begin
			ack_o   <= (addr_i != err_addr_i);
			err_o   <= (addr_i == err_addr_i);
			rdata_o <= addr_i + 32'h0000_0100;
		end else begin
			wait_q  <= wait_q + 4'h1;
			rdata_o <= ~rdata_o;
		end
	end
endmodule // sys_memory_model

// ==== test_usb_host_port_block.sv ====
/*
 * Self-checking bench of the host port wrapper with a memory model.
 * Assumes the wrapper, its FIFO and the memory model are compiled first.
 */
`timescale 1ns/1ps
module test_usb_host_port_block;
	logic        clock_i, reset_n_i, op_req_i, op_we_i, mst_req_o, mst_we_o, mst_ack_i, mst_err_i;
	logic [3:0]  op_addr_i, fullspeed_clock_divider_i, mem_latency;
	logic [31:0] op_wdata_i, op_rdata_o, mst_addr_o, mst_wdata_o, mst_rdata_i, tx_data_o, err_addr, rd_val;
	logic        tx_valid_o, tx_ready_i, utmi_pll_enable_bit_i, utmi_pll_lock_flag_i, transceiver_bias_enable_i;
	logic        xcvr_30m_valid_i, fullspeed_clock_source_select_i, host_clock_enable_bit_i, host_48m_tick_i;
	logic        host_12m_tick_o, hs_available_o, fs_ready_o, clock_config_error_o, device_port_enable_i;
	logic        port_a_fullspeed_oe_o, port_a_highspeed_oe_o, device_fullspeed_oe_i, device_highspeed_oe_i;
	logic        port_b_fullspeed_oe_o, port_b_highspeed_oe_o, irq_o;
	logic [1:0]  port_a_line_state_i, port_b_line_state_i, oc_sense_i, port_power_o, port_a_fullspeed_o;
	logic [1:0]  port_a_highspeed_o, device_fullspeed_i, device_highspeed_i, port_b_fullspeed_o, port_b_highspeed_o;
	logic [31:0] log_addr[$];
	logic [31:0] log_data[$];
	int          err_total, checks_done;

	// ========================================
	// harness
	usb_host_port_block usb_host_port_block_inst (.clock_i, .reset_n_i, .op_req_i, .op_we_i, .op_addr_i,
		.op_wdata_i, .op_rdata_o, .mst_req_o, .mst_we_o, .mst_addr_o, .mst_wdata_o, .mst_ack_i, .mst_err_i,
		.mst_rdata_i, .tx_valid_o, .tx_ready_i, .tx_data_o, .utmi_pll_enable_bit_i, .utmi_pll_lock_flag_i,
		.transceiver_bias_enable_i, .xcvr_30m_valid_i, .fullspeed_clock_source_select_i,
		.fullspeed_clock_divider_i, .host_clock_enable_bit_i, .host_48m_tick_i, .host_12m_tick_o,
		.hs_available_o, .fs_ready_o, .clock_config_error_o, .port_a_line_state_i, .port_b_line_state_i,
		.oc_sense_i, .port_power_o, .port_a_fullspeed_o, .port_a_fullspeed_oe_o, .port_a_highspeed_o,
		.port_a_highspeed_oe_o, .device_port_enable_i, .device_fullspeed_i, .device_fullspeed_oe_i,
		.device_highspeed_i, .device_highspeed_oe_i, .port_b_fullspeed_o, .port_b_fullspeed_oe_o,
		.port_b_highspeed_o, .port_b_highspeed_oe_o, .irq_o);
	sys_memory_model sys_memory_model_inst (.clock_i, .reset_n_i, .req_i(mst_req_o), .addr_i(mst_addr_o),
		.latency_i(mem_latency), .err_addr_i(err_addr), .ack_o(mst_ack_i), .err_o(mst_err_i),
		.rdata_o(mst_rdata_i));

	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	// completed master accesses, write data or zero for reads
	always @(negedge clock_i) begin
		if (mst_req_o === 1'b1 && mst_ack_i === 1'b1) begin
			log_addr.push_back(mst_addr_o);
			log_data.push_back(mst_we_o ? mst_wdata_o : 32'h0000_0000);
		end
	end

	// ========================================
	// helpers
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		op_req_i = 1'b1;
		op_we_i = 1'b1;
		op_addr_i = a;
		op_wdata_i = d;
		cyc(1);
		op_req_i = 1'b0;
		op_we_i = 1'b0;
		cyc(1);
	endtask

	task automatic rd(input logic [3:0] a);
		op_req_i = 1'b1;
		op_addr_i = a;
		cyc(1);
		op_req_i = 1'b0;
		rd_val = op_rdata_o;
		cyc(1);
	endtask

	task automatic wait_irq(input string what);
		int k;
		for (k = 0; k < 60 && irq_o !== 1'b1; k++) cyc(1);
		if (k == 60) give_up(what);
	endtask

	task automatic give_up(input string what);
		err_total++;
		$display("CHECK FAILED at %0t: timeout %s", $time, what);
		complete_run();
	endtask

	// ========================================
	// scenarios
	task automatic t_regs();
		rd(4'h0);
		check(rd_val, 32'h0000_0018, "control reset");
		wr(4'hF, 32'hFFFF_FFFF);
		rd(4'hF);
		check(rd_val, 32'h0000_0000, "unmapped read");
		rd(4'h0);
		check(rd_val, 32'h0000_0018, "unmapped write");
		rd(4'h2);
		check(32'(rd_val[3:0]), 32'h0000_0002, "port count");
		$display("test regs done");
	endtask

	task automatic t_clocks();
		logic [3:0] c;
		int         n;
		for (int i = 0; i < 16; i++) begin
			c = 4'(i);
			{utmi_pll_enable_bit_i, utmi_pll_lock_flag_i, transceiver_bias_enable_i, xcvr_30m_valid_i} = c;
			cyc(8);
			check(32'(hs_available_o), 32'(&c), "hs available");
		end
		utmi_pll_enable_bit_i = 1'b0;
		fullspeed_clock_source_select_i = 1'b0;
		fullspeed_clock_divider_i = 4'h3;
		host_clock_enable_bit_i = 1'b1;
		cyc(8);
		check(32'({fs_ready_o, clock_config_error_o}), 32'h2, "main source");
		fullspeed_clock_source_select_i = 1'b1;
		cyc(1);
		check(32'({fs_ready_o, clock_config_error_o}), 32'h1, "utmi source off");
		utmi_pll_enable_bit_i = 1'b1;
		cyc(8);
		fullspeed_clock_divider_i = 4'h9;
		cyc(1);
		check(32'({fs_ready_o, clock_config_error_o}), 32'h2, "utmi source on");
		n = 0;
		host_48m_tick_i = 1'b1;
		repeat (40) begin
			#20;
			if (host_12m_tick_o === 1'b1) n++;
			cyc(1);
		end
		host_48m_tick_i = 1'b0;
		check(32'(n), 32'd10, "12m ticks");
		$display("test clocks done");
	endtask

	task automatic t_master();
		logic [31:0] ea[7] = '{32'h1000, 32'h1100, 32'h1200, 32'h1204, 32'h1208, 32'h120C, 32'h1100};
		int          k;
		mem_latency = 4'h2;
		wr(4'h3, 32'h0000_1000);
		wr(4'h0, 32'h0000_001B);
		for (k = 0; k < 1000 && log_addr.size() < 30; k++) cyc(1);
		if (k == 1000) give_up("fifo fill");
		cyc(20);
		check(32'(log_addr.size()), 32'd30, "stall at full");
		check(32'({mst_req_o, tx_valid_o}), 32'h1, "request dropped");
		rd(4'h1);
		check(32'(rd_val[5:0]), 32'h38, "busy status");
		for (int i = 0; i < 28; i++) begin
			check(log_addr[i], ea[i % 7], "master address");
			check(log_data[i], (i % 7 == 6) ? 32'h1100 : 32'h0, "write back");
		end
		wr(4'h0, 32'h0000_001A);
		tx_ready_i = 1'b1;
		k = 0;
		repeat (200) begin
			if (tx_valid_o === 1'b1) begin
				check(tx_data_o, 32'h1300 + 32'(4 * (k % 4)), "endpoint data");
				k++;
			end
			cyc(1);
		end
		check(32'(k), 32'd20, "drained words");
		check(32'(log_addr.size()), 32'd35, "final accesses");
		$display("test master done");
	endtask

	task automatic t_error();
		int n;
		mem_latency = 4'h0;
		err_addr = 32'h0000_2000;
		wr(4'h3, 32'h0000_2000);
		wr(4'h0, 32'h0000_001B);
		wait_irq("abort");
		n = log_addr.size();
		rd(4'h1);
		check(32'(rd_val[0]), 32'h1, "abort flag");
		cyc(10);
		check(32'(mst_req_o), 32'h0, "halted");
		wr(4'h0, 32'h0000_0018);
		check(32'(irq_o), 32'h0, "masked");
		wr(4'h1, 32'h0000_0001);
		rd(4'h1);
		check(32'(rd_val[0]), 32'h0, "flag cleared");
		wr(4'h3, 32'h0000_3002);
		wr(4'h0, 32'h0000_001B);
		wait_irq("misaligned");
		check(32'(log_addr.size()), 32'(n), "no misaligned access");
		wr(4'h0, 32'h0000_0018);
		wr(4'h1, 32'h0000_0001);
		$display("test error done");
	endtask

	task automatic t_ports();
		wr(4'h0, 32'h0000_001A);
		port_a_line_state_i = 2'b01;
		wait_irq("attach");
		rd(4'h1);
		check(32'(rd_val[2:1]), 32'h1, "attach seen");
		wr(4'h1, 32'h0000_0006);
		check(32'({irq_o, port_power_o}), 32'h3, "cleared, powered");
		wr(4'h0, 32'h0000_001E);
		oc_sense_i = 2'b01;
		cyc(8);
		check(32'(port_power_o), 32'h2, "over-current");
		oc_sense_i = 2'b00;
		wr(4'h0, 32'h0000_007A);
		check(32'({port_a_fullspeed_oe_o, port_a_fullspeed_o, port_a_highspeed_oe_o, port_a_highspeed_o,
			port_b_fullspeed_oe_o, port_b_fullspeed_o, port_b_highspeed_oe_o, port_b_highspeed_o}),
			32'h924, "port reset");
		wr(4'h0, 32'h0000_001A);
		check(32'({port_a_fullspeed_oe_o, port_a_highspeed_oe_o, port_b_fullspeed_oe_o,
			port_b_highspeed_oe_o}), 32'h0, "lines released");
		port_b_line_state_i = 2'b10;
		wait_irq("attach B");
		rd(4'h1);
		check(32'(rd_val[2:1]), 32'h2, "attach B seen");
		wr(4'h1, 32'h0000_0004);
		device_port_enable_i = 1'b1;
		{device_fullspeed_oe_i, device_fullspeed_i, device_highspeed_oe_i, device_highspeed_i} = 6'b110101;
		wr(4'h0, 32'h0000_007A);
		check(32'({port_b_fullspeed_oe_o, port_b_fullspeed_o, port_b_highspeed_oe_o, port_b_highspeed_o}),
			32'h35, "device owns B");
		check(32'({port_a_fullspeed_oe_o, port_power_o}), 32'h5, "host on A only");
		rd(4'h2);
		check(32'(rd_val[3:0]), 32'h1, "shared port count");
		check(32'(rd_val[9:8]), 32'h1, "port B hidden from host");
		$display("test ports done");
	endtask

	// ========================================
	// main
	initial begin
		{op_req_i, op_we_i, op_addr_i, op_wdata_i, tx_ready_i, host_48m_tick_i} = '0;
		{utmi_pll_enable_bit_i, utmi_pll_lock_flag_i, transceiver_bias_enable_i, xcvr_30m_valid_i} = 4'h0;
		{fullspeed_clock_source_select_i, fullspeed_clock_divider_i, host_clock_enable_bit_i} = 6'h00;
		{port_a_line_state_i, port_b_line_state_i, oc_sense_i, device_port_enable_i} = 7'h00;
		{device_fullspeed_i, device_fullspeed_oe_i, device_highspeed_i, device_highspeed_oe_i} = 6'h00;
		{err_total, checks_done} = '0;
		mem_latency = 4'h0;
		err_addr = 32'hFFFF_FFF0;
		reset_n_i = 1'b0;
		cyc(12);
		reset_n_i = 1'b1;
		t_regs();
		t_clocks();
		t_master();
		t_error();
		t_ports();
		complete_run();
	end
endmodule // test_usb_host_port_block
